// *** rtl/bcl_pkg.sv ***
// Constants and carrier types of the branch cache tuning and lock block.
package bcl_pkg;

    // ==========================================================
    // Widths
    localparam int SLOT_W = 6;
    localparam int ACC_W  = 12;
    localparam int ADDR_W = 16;
    localparam int WAIT_W = 8;
    localparam int IRQ_W  = 4;

    // ==========================================================
    // Register offsets
    localparam logic [7:0] ADDR_FLASH_STATE = 8'h88;
    localparam logic [7:0] ADDR_MISS_ACC    = 8'h9a;
    localparam logic [7:0] ADDR_TUNING      = 8'ha2;
    localparam logic [7:0] ADDR_LOCK        = 8'ha3;
    localparam logic [7:0] ADDR_IRQ_STATUS  = 8'hb4;
    localparam logic [7:0] ADDR_IRQ_MASK    = 8'hb5;

    // ==========================================================
    // Field positions
    localparam int TN_ALGO_BIT = 3;
    localparam int TN_FIX_BIT  = 2;
    localparam int LC_PUSH_BIT = 7;
    localparam int LC_POP_BIT  = 6;
    localparam int MA_OV_BIT   = 7;
    localparam int IRQ_OV      = 0;
    localparam int IRQ_PUSH    = 1;
    localparam int IRQ_POP     = 2;
    localparam int IRQ_FLASH   = 3;

    // ==========================================================
    // Reset values and fixed figures
    localparam logic              ALGO_RST  = 1'b0;
    localparam logic              FIX_RST   = 1'b1;
    localparam logic [1:0]        THR_RST   = 2'h0;
    localparam logic [SLOT_W-1:0] PTR_RST   = 6'h3f;
    localparam logic [SLOT_W-1:0] SLOT_MAX  = 6'h3f;
    localparam logic [SLOT_W-1:0] SLOT_ZERO = 6'h00;
    localparam logic [SLOT_W-1:0] SLOT_ONE  = 6'h01;
    localparam logic [ACC_W-1:0]  ACC_ONE   = 12'h001;
    localparam logic [ACC_W-1:0]  ACC_FULL  = 12'hfff;
    localparam logic [7:0]        LFSR_SEED = 8'h5a;
    localparam logic [7:0]        LFSR_TAPS = 8'hb8;
    localparam logic [IRQ_W-1:0]  IRQ_NONE  = 4'h0;

    // ==========================================================
    // Carrier types
    typedef struct packed {
        logic              valid;
        logic              movc;
        logic [WAIT_W-1:0] wait_cycles;
    } bcl_fill_t;

    typedef struct packed {
        logic              we;
        logic              lock;
        logic [SLOT_W-1:0] slot;
    } bcl_cache_wr_t;

    typedef struct packed {
        logic              valid;
        logic [SLOT_W-1:0] slot;
    } bcl_unlock_t;

    typedef struct packed {
        logic              valid;
        logic [ADDR_W-1:0] addr;
    } bcl_flash_t;

endpackage : bcl_pkg

// *** rtl/bcl_ctrl.sv ***
// Tuning, lock stack and miss diagnostics of the branch target cache.
//
// Overview of operation
// - Rebound order replaces slots when algorithm bit is 0, random when 1.
// - Fixed-slot bit set sends every MOVC fill to slot 0 unless push is enabled.
// - Instruction miss data is cached only if fetch exceeded the threshold.
// - Push enabled: a MOVC fill locks the pointer slot, then decrements it.
// - Pointer zero unlocks the whole cache; keep at most 62 slots locked.
// - Writing pop increments the pointer and unlocks that slot; pop reads 0.
// - Pointer is read-only; slots above it stay unless the pointer is 0.
// - Accumulator counts every cycle the core stalls on a cache miss.
// - Overflow flag shows a wrap since the last software write.
// - Accumulator bits 11-5 and 4-1 are readable; bit 0 is hidden.
// - Writing the high field clears the accumulator's low five bits.
// - Reading the high field latches bits 4-1 into the low field.
// - Flash busy reads 1 during flash write or erase, else 0.
// - Flash write or erase always invalidates the affected cache bytes.
// - Pop unlocks only the last locked slot and keeps its contents.
//
// The strobed register port was decided locally.
`timescale 1ns/10ps
module bcl_ctrl (
    // Clock and reset
    input  wire logic                          mclk,
    input  wire logic                          rst_n,
    // Register port
    input  wire logic [7:0]                    reg_addr,
    input  wire logic [7:0]                    reg_wdata,
    input  wire logic                          reg_wr,
    input  wire logic                          reg_rd,
    output logic      [7:0]                    reg_rdata,
    // Core and flash side
    input  wire bcl_pkg::bcl_fill_t            fill,
    input  wire logic                          stall_miss,
    input  wire logic                          flash_busy_in,
    input  wire bcl_pkg::bcl_flash_t           flash_prog,
    // Cache array side
    output bcl_pkg::bcl_cache_wr_t             cache_wr,
    output bcl_pkg::bcl_unlock_t               cache_unlock,
    output bcl_pkg::bcl_flash_t                cache_inv,
    output logic      [bcl_pkg::SLOT_W-1:0]    lock_ptr,
    output logic                               lock_active,
    // Interrupt
    output logic                               irq
);

    // ==========================================================
    // Functions

    // Folds a candidate slot into the unlocked range 0..ptr.
    function automatic logic [bcl_pkg::SLOT_W-1:0] legal_slot(
        input logic [bcl_pkg::SLOT_W-1:0] s,
        input logic [bcl_pkg::SLOT_W-1:0] ptr
    );
        logic [bcl_pkg::SLOT_W-1:0] f;
        f = s - ptr - bcl_pkg::SLOT_ONE;
        if (ptr == bcl_pkg::SLOT_ZERO || s <= ptr) begin
            legal_slot = s;
        end else if (f <= ptr) begin
            legal_slot = f;
        end else begin
            legal_slot = ptr;
        end
    endfunction : legal_slot

    // Moves a slot number one place up or down, wrapping at the ends.
    function automatic logic [bcl_pkg::SLOT_W-1:0] slot_step(
        input logic [bcl_pkg::SLOT_W-1:0] s,
        input logic                       up
    );
        if (up) begin
            slot_step = s + bcl_pkg::SLOT_ONE;
        end else begin
            slot_step = s - bcl_pkg::SLOT_ONE;
        end
    endfunction : slot_step

    // Tells whether a strobe addresses the given register.
    function automatic logic reg_hit(
        input logic       strobe,
        input logic [7:0] addr,
        input logic [7:0] offset
    );
        reg_hit = strobe && addr == offset;
    endfunction : reg_hit

    // ==========================================================
    // State
    logic                        algo_sel;
    logic                        fixed_slot;
    logic [1:0]                  thr;
    logic                        push_en;
    logic [bcl_pkg::SLOT_W-1:0]  ptr;
    logic [bcl_pkg::ACC_W-1:0]   acc;
    logic                        acc_ov;
    logic [3:0]                  acc_low;
    logic [bcl_pkg::SLOT_W-1:0]  reb_pos;
    logic                        reb_up;
    logic [7:0]                  lfsr;
    logic                        busy_q;
    logic [bcl_pkg::IRQ_W-1:0]   irq_status;
    logic [bcl_pkg::IRQ_W-1:0]   irq_mask;

    // ==========================================================
    // Decode
    logic                        wr_tn;
    logic                        wr_lc;
    logic                        wr_ma;
    logic                        rd_ma;
    logic                        wr_msk;
    logic                        rd_st;
    logic                        pop_req;
    logic [bcl_pkg::SLOT_W-1:0]  limit;
    logic [bcl_pkg::SLOT_W-1:0]  algo_slot;
    logic [bcl_pkg::SLOT_W-1:0]  reb_cur;
    logic                        push_do;
    logic                        algo_do;
    logic                        fix_do;
    logic                        acc_wrap;
    logic                        flash_done;
    logic [bcl_pkg::IRQ_W-1:0]   irq_set;
    logic [bcl_pkg::ACC_W-1:0]   next_acc;

    assign wr_tn   = reg_hit(reg_wr, reg_addr, bcl_pkg::ADDR_TUNING);
    assign wr_lc   = reg_hit(reg_wr, reg_addr, bcl_pkg::ADDR_LOCK);
    assign wr_ma   = reg_hit(reg_wr, reg_addr, bcl_pkg::ADDR_MISS_ACC);
    assign rd_ma   = reg_hit(reg_rd, reg_addr, bcl_pkg::ADDR_MISS_ACC);
    assign wr_msk  = reg_hit(reg_wr, reg_addr, bcl_pkg::ADDR_IRQ_MASK);
    assign rd_st   = reg_hit(reg_rd, reg_addr, bcl_pkg::ADDR_IRQ_STATUS);
    assign pop_req = wr_lc && reg_wdata[bcl_pkg::LC_POP_BIT];

    assign limit = (ptr == bcl_pkg::SLOT_ZERO) ?
        bcl_pkg::SLOT_MAX : ptr;
    assign reb_cur = (reb_pos > limit) ? bcl_pkg::SLOT_ZERO : reb_pos;
    assign algo_slot = algo_sel ?
        legal_slot(lfsr[bcl_pkg::SLOT_W-1:0], ptr) : reb_cur;

    always_comb begin
        push_do = 1'b0;
        algo_do = 1'b0;
        fix_do  = 1'b0;
        if (fill.valid) begin
            if (fill.movc) begin
                if (push_en) begin
                    push_do = 1'b1;
                end else if (fixed_slot) begin
                    fix_do = 1'b1;
                end else begin
                    algo_do = 1'b1;
                end
            end else if (fill.wait_cycles > {6'h00, thr}) begin
                algo_do = 1'b1;
            end
        end
    end

    assign acc_wrap   = stall_miss && acc == bcl_pkg::ACC_FULL;
    assign flash_done = busy_q && !flash_busy_in;

    always_comb begin
        irq_set = bcl_pkg::IRQ_NONE;
        irq_set[bcl_pkg::IRQ_OV]    = acc_wrap;
        irq_set[bcl_pkg::IRQ_PUSH]  = push_do;
        irq_set[bcl_pkg::IRQ_POP]   = pop_req;
        irq_set[bcl_pkg::IRQ_FLASH] = flash_done;
    end

    always_comb begin
        next_acc = acc;
        if (wr_ma) begin
            next_acc = {reg_wdata[6:0], 5'h00};
        end
        if (stall_miss) begin
            next_acc = next_acc + bcl_pkg::ACC_ONE;
        end
    end

    // ==========================================================
    // Tuning register
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            algo_sel   <= bcl_pkg::ALGO_RST;
            fixed_slot <= bcl_pkg::FIX_RST;
            thr        <= bcl_pkg::THR_RST;
        end else if (wr_tn) begin
            algo_sel   <= reg_wdata[bcl_pkg::TN_ALGO_BIT];
            fixed_slot <= reg_wdata[bcl_pkg::TN_FIX_BIT];
            thr        <= reg_wdata[1:0];
        end
    end

    // ==========================================================
    // Lock stack
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            push_en <= 1'b0;
            ptr     <= bcl_pkg::PTR_RST;
        end else begin
            if (wr_lc) begin
                push_en <= reg_wdata[bcl_pkg::LC_PUSH_BIT];
            end
            case ({push_do, pop_req})
                2'b10: ptr <= slot_step(ptr, 1'b0);
                2'b01: ptr <= slot_step(ptr, 1'b1);
                default: ptr <= ptr;
            endcase
        end
    end

    // ==========================================================
    // Replacement choice
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            lfsr <= bcl_pkg::LFSR_SEED;
        end else if (lfsr[0]) begin
            lfsr <= (lfsr >> 1) ^ bcl_pkg::LFSR_TAPS;
        end else begin
            lfsr <= lfsr >> 1;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            reb_pos <= bcl_pkg::SLOT_ZERO;
            reb_up  <= 1'b1;
        end else if (reb_pos > limit) begin
            reb_pos <= bcl_pkg::SLOT_ZERO;
            reb_up  <= 1'b1;
        end else if (algo_do && !algo_sel) begin
            if (reb_up && reb_pos == limit) begin
                reb_up  <= 1'b0;
                reb_pos <= slot_step(reb_pos, 1'b0);
            end else if (!reb_up && reb_pos == bcl_pkg::SLOT_ZERO) begin
                reb_up  <= 1'b1;
                reb_pos <= slot_step(reb_pos, 1'b1);
            end else begin
                reb_pos <= slot_step(reb_pos, reb_up);
            end
        end
    end

    // ==========================================================
    // Cache array commands
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            cache_wr     <= '0;
            cache_unlock <= '0;
            cache_inv    <= '0;
            lock_ptr     <= bcl_pkg::PTR_RST;
            lock_active  <= 1'b1;
        end else begin
            cache_wr.we   <= push_do || fix_do || algo_do;
            cache_wr.lock <= push_do;
            if (push_do) begin
                cache_wr.slot <= ptr;
            end else if (fix_do) begin
                cache_wr.slot <= bcl_pkg::SLOT_ZERO;
            end else begin
                cache_wr.slot <= algo_slot;
            end
            cache_unlock.valid <= pop_req;
            cache_unlock.slot  <= slot_step(ptr, 1'b1);
            cache_inv          <= flash_prog;
            lock_ptr           <= ptr;
            lock_active        <= ptr != bcl_pkg::SLOT_ZERO;
        end
    end

    // ==========================================================
    // Miss penalty accumulator
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            acc    <= '0;
            acc_ov <= 1'b0;
        end else begin
            acc <= next_acc;
            if (acc_wrap) begin
                acc_ov <= 1'b1;
            end else if (wr_ma) begin
                acc_ov <= 1'b0;
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            acc_low <= 4'h0;
        end else if (rd_ma) begin
            acc_low <= acc[4:1];
        end
    end

    // ==========================================================
    // Interrupts
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            busy_q     <= 1'b0;
            irq_status <= bcl_pkg::IRQ_NONE;
            irq_mask   <= bcl_pkg::IRQ_NONE;
            irq        <= 1'b0;
        end else begin
            busy_q <= flash_busy_in;
            if (rd_st) begin
                irq_status <= irq_set;
            end else begin
                irq_status <= irq_status | irq_set;
            end
            if (wr_msk) begin
                irq_mask <= reg_wdata[bcl_pkg::IRQ_W-1:0];
            end
            irq <= |(irq_status & irq_mask);
        end
    end

    // ==========================================================
    // Read data
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            case (reg_addr)
                bcl_pkg::ADDR_FLASH_STATE:
                    reg_rdata <= {7'h00, flash_busy_in};
                bcl_pkg::ADDR_MISS_ACC:
                    reg_rdata <= {acc_ov, acc[11:5]};
                bcl_pkg::ADDR_TUNING:
                    reg_rdata <= {acc_low, algo_sel, fixed_slot, thr};
                bcl_pkg::ADDR_LOCK:
                    reg_rdata <= {push_en, 1'b0, ptr};
                bcl_pkg::ADDR_IRQ_STATUS:
                    reg_rdata <= {4'h0, irq_status};
                bcl_pkg::ADDR_IRQ_MASK:
                    reg_rdata <= {4'h0, irq_mask};
                default:
                    reg_rdata <= 8'h00;
            endcase
        end else begin
            reg_rdata <= 8'h00;
        end
    end

endmodule : bcl_ctrl

// *** sim/bcl_ctrl_assertions.sv ***
// Assertion checker of the branch cache tuning and lock block.
`timescale 1ns/10ps
module bcl_chk (
    // Clock and reset
    input wire logic                       mclk,
    input wire logic                       rst_n,
    // Watched ports
    input wire logic [7:0]                 reg_addr,
    input wire logic                       reg_rd,
    input wire logic [7:0]                 reg_rdata,
    input wire bcl_pkg::bcl_fill_t         fill,
    input wire bcl_pkg::bcl_flash_t        flash_prog,
    input wire bcl_pkg::bcl_cache_wr_t     cache_wr,
    input wire bcl_pkg::bcl_unlock_t       cache_unlock,
    input wire bcl_pkg::bcl_flash_t        cache_inv,
    input wire logic [bcl_pkg::SLOT_W-1:0] lock_ptr,
    input wire logic                       lock_active
);
    // ====
    // Properties
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    property p_inv;
        flash_prog.valid |=> cache_inv.valid
            && cache_inv.addr == $past(flash_prog.addr);
    endproperty
    a_inv: assert property (p_inv) else $error("lost invalidate");
    property p_thr;
        fill.valid && !fill.movc && fill.wait_cycles == 8'h00
            |=> !cache_wr.we;
    endproperty
    a_thr: assert property (p_thr) else $error("fast miss cached");
    property p_src;
        cache_wr.we |-> $past(fill.valid);
    endproperty
    a_src: assert property (p_src) else $error("write without fill");
    property p_push;
        cache_wr.lock |-> cache_wr.we && cache_wr.slot == lock_ptr;
    endproperty
    a_push: assert property (p_push) else $error("push slot wrong");
    property p_dec;
        cache_wr.lock |=> lock_ptr == $past(lock_ptr) - 6'h01;
    endproperty
    a_dec: assert property (p_dec) else $error("no decrement");
    property p_keep;
        cache_wr.we && !cache_wr.lock && lock_active
            |-> cache_wr.slot <= lock_ptr;
    endproperty
    a_keep: assert property (p_keep) else $error("locked slot hit");
    property p_pop;
        cache_unlock.valid |-> cache_unlock.slot == lock_ptr + 6'h01
            ##1 lock_ptr == $past(cache_unlock.slot);
    endproperty
    a_pop: assert property (p_pop) else $error("bad pop");
    property p_act;
        lock_active == (lock_ptr != 6'h00);
    endproperty
    a_act: assert property (p_act) else $error("lock state wrong");
    property p_poprd;
        reg_rd && reg_addr == bcl_pkg::ADDR_LOCK |=> !reg_rdata[6];
    endproperty
    a_poprd: assert property (p_poprd) else $error("pop reads 1");
endmodule : bcl_chk

bind bcl_ctrl bcl_chk u_chk (.mclk(mclk), .rst_n(rst_n),
    .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .fill(fill), .flash_prog(flash_prog), .cache_wr(cache_wr),
    .cache_unlock(cache_unlock), .cache_inv(cache_inv),
    .lock_ptr(lock_ptr), .lock_active(lock_active));

// *** sim/bcl_core_model.sv ***
// Core model that stalls on misses, fills the cache and programs flash.
`timescale 1ns/10ps
module bcl_core_model (
    // Clock
    input wire logic            mclk,
    // Core side
    output bcl_pkg::bcl_fill_t  fill,
    output logic                stall_miss,
    output logic                flash_busy_in,
    output bcl_pkg::bcl_flash_t flash_prog
);
    initial begin
        fill = '0;
        stall_miss = 1'b0;
        flash_busy_in = 1'b0;
        flash_prog = '0;
    end
    // Stalls n cycles, then hands the fetched entry over.
    task automatic fetch(input logic mv, input logic [7:0] n);
        repeat (n) begin
            stall_miss <= 1'b1;
            @(posedge mclk);
        end
        stall_miss <= 1'b0;
        fill <= '{1'b1, mv, n};
        @(posedge mclk);
        fill <= '{1'b0, ~mv, ~n};
        repeat (2) @(posedge mclk);
    endtask : fetch
    // Programs one flash byte and leaves busy as given.
    task automatic flash_op(input logic [15:0] a, input logic b);
        flash_busy_in <= b;
        flash_prog <= '{1'b1, a};
        @(posedge mclk);
        flash_prog <= '{1'b0, ~a};
        @(posedge mclk);
    endtask : flash_op
endmodule : bcl_core_model

// *** sim/testbench.sv ***
// Self-checking bench of the branch cache tuning and lock block.
`timescale 1ns/10ps
module testbench;
    logic                   mclk, rst_n, reg_wr, reg_rd, lock_active, irq;
    logic [7:0]             reg_addr, reg_wdata, reg_rdata, n;
    logic [6:0]             h;
    logic [11:0]            acc;
    logic [5:0]             lock_ptr, last_slot, k6;
    logic                   last_lock;
    bcl_pkg::bcl_fill_t     fill;
    bcl_pkg::bcl_flash_t    flash_prog, cache_inv;
    bcl_pkg::bcl_cache_wr_t cache_wr;
    bcl_pkg::bcl_unlock_t   cache_unlock;
    logic                   stall_miss, flash_busy_in;
    int                     miscompares, checks, nwr, i, k;
    integer                 seed;
    initial mclk = 1'b0;
    always #50 mclk = ~mclk;
    bcl_ctrl u_bcl_ctrl (.mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .fill(fill), .stall_miss(stall_miss),
        .flash_busy_in(flash_busy_in), .flash_prog(flash_prog),
        .cache_wr(cache_wr), .cache_unlock(cache_unlock),
        .cache_inv(cache_inv), .lock_ptr(lock_ptr),
        .lock_active(lock_active), .irq(irq));
    bcl_core_model u_bcl_core_model (.mclk(mclk), .fill(fill),
        .stall_miss(stall_miss), .flash_busy_in(flash_busy_in),
        .flash_prog(flash_prog));
    always @(posedge mclk) begin
        if (cache_wr.we) begin
            nwr <= nwr + 1;
            last_slot <= cache_wr.slot;
            last_lock <= cache_wr.lock;
        end
    end
    // ====
    // Tasks and functions
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            miscompares++;
            $display("FAIL t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
        @(posedge mclk);
    endtask : wr
    task automatic rdc(input logic [7:0] a, input logic [7:0] e);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        @(negedge mclk);
        chk(reg_rdata, e);
        @(posedge mclk);
    endtask : rdc
    function automatic logic [7:0] f_hi(input logic [11:0] a, input logic o);
        return {o, a[11:5]};
    endfunction : f_hi
    function automatic logic [7:0] f_lo(input logic [11:0] a);
        return {a[4:1], 4'h4};
    endfunction : f_lo
    task automatic print_verdict();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : print_verdict
    initial begin
        #500000;
        miscompares++;
        print_verdict();
    end
    // ====
    // Main sequence
    initial begin
        seed = 32'h6f57;
        {miscompares, checks, nwr} = '0;
        {rst_n, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
        repeat (8) @(posedge mclk);
        rst_n <= 1'b1;
        @(posedge mclk);
        rdc(8'ha2, 8'h04);
        rdc(8'ha3, 8'h3f);
        rdc(8'h9a, 8'h00);
        wr(8'h57, 8'hff);
        rdc(8'h57, 8'h00);
        rdc(8'h88, 8'h00);
        $display("reset test done");
        for (i = 0; i < 3; i++) begin
            n = 8'(($random(seed) & 32'h1f) + 1);
            h = 7'($random(seed)) & 7'h7e;
            wr(8'h9a, {1'b0, h});
            u_bcl_core_model.fetch(1'b0, n);
            acc = {h, 5'h00} + 12'(n);
            rdc(8'h9a, f_hi(acc, 1'b0));
            rdc(8'ha2, f_lo(acc));
        end
        $display("accumulator test done");
        rdc(8'hb4, 8'h00);
        wr(8'hb5, 8'h01);
        wr(8'h9a, 8'h7f);
        u_bcl_core_model.fetch(1'b0, 8'h28);
        chk(8'(irq), 8'h01);
        rdc(8'h9a, f_hi(12'h008, 1'b1));
        rdc(8'ha2, f_lo(12'h008));
        rdc(8'hb4, 8'h01);
        @(negedge mclk);
        chk(8'(irq), 8'h00);
        @(posedge mclk);
        wr(8'h9a, 8'h05);
        rdc(8'h9a, 8'h05);
        wr(8'hb5, 8'h00);
        $display("overflow test done");
        wr(8'ha2, 8'h02);
        for (i = 0; i < 5; i++) begin
            k = nwr;
            u_bcl_core_model.fetch(1'b0, 8'(i));
            chk(8'(nwr - k), 8'(i > 2));
        end
        k6 = last_slot;
        u_bcl_core_model.fetch(1'b0, 8'h05);
        k = (last_slot == k6 + 6'h01 || last_slot == k6 - 6'h01);
        chk(8'(k), 8'h01);
        wr(8'ha2, 8'h04);
        u_bcl_core_model.fetch(1'b1, 8'd1);
        chk(8'(last_slot), 8'h00);
        wr(8'ha2, 8'h08);
        for (i = 0; i < 20; i++)
            u_bcl_core_model.fetch(1'($random(seed)),
                8'(($random(seed) & 3) + 1));
        $display("replacement test done");
        wr(8'ha3, 8'h80);
        for (i = 0; i < 3; i++) begin
            u_bcl_core_model.fetch(1'b1, 8'd1);
            chk(8'({last_lock, last_slot}), 8'(7'h7f - 7'(i)));
        end
        rdc(8'ha3, 8'hbc);
        for (i = 0; i < 2; i++) begin
            wr(8'ha3, 8'h40);
            rdc(8'ha3, 8'h3d + 8'(i));
        end
        u_bcl_core_model.fetch(1'b0, 8'h02);
        $display("lock test done");
        u_bcl_core_model.flash_op(16'($random(seed)), 1'b1);
        rdc(8'h88, 8'h01);
        u_bcl_core_model.flash_op(16'($random(seed)), 1'b0);
        rdc(8'h88, 8'h00);
        rdc(8'hb4, 8'h0e);
        $display("flash test done");
        print_verdict();
    end
endmodule : testbench
